//--- flash_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Descriptor: id, size, page, planes, plane sizes
// - Then lock count and region sizes
// - Erase-write commands erase page before writing
// - Lock variants set page's region lock after programming, or the command argument's region if a command write lands that cycle
// - Page latch wraps across whole latch window
// - Latch writes use configured wait states
// - Programming command starts work, clears done
// - Completion sets done, interrupt if enabled
// - Wrong keyword rejected, command error set
// - Programming locked page sets lock error
// - Plain write page never erases
// - Erase starts on command, done on completion
// - Erase touching locked region wholly refused
// - Lock bit blocks writes and erases
// - Set-lock locks page's region, then done
// - Out-of-range lock number changes nothing
// - Clear-lock unlocks region, then done
// - Get-lock returns 32 bits per read, then zero
// - Bit n of word is region n
// - Reads allowed during lock commands
// - Command codes as fixed in the package
// - Reading status clears both error flags
// - Known command write clears done and result; unknown code clears result only
module flash_sequencer
	import flash_seq_pkg::*;
#(
	parameter int         PAGE_WORDS  = 16,
	parameter int         NUM_PAGES   = 256,
	parameter int         REGION_PGS  = 16,
	parameter int         NUM_LOCKS   = 16,
	parameter int         NUM_PLANES  = 1,
	parameter logic [7:0] CMD_KEY     = 8'hC3,          // Arbitrary keyword value
	parameter logic [31:0] IFACE_WORD = 32'h0000_1234   // Arbitrary identity value
) (
	input  wire logic                          i_clk,
	input  wire logic                          i_rst_n,
	input  wire logic                          i_psel,
	input  wire logic                          i_penable,
	input  wire logic                          i_pwrite,
	input  wire logic [11:0]                   i_paddr,
	input  wire logic [31:0]                   i_pwdata,
	output var  logic [31:0]                   o_prdata,
	output var  logic                          o_pready,
	output var  logic                          o_pslverr,
	output var  logic                          o_arr_req,
	output var  logic [1:0]                    o_arr_op,
	output var  logic [15:0]                   o_arr_page,
	output var  logic [$clog2(PAGE_WORDS)-1:0] o_arr_widx,
	output var  logic [31:0]                   o_arr_wdata,
	input  wire logic                          i_arr_ack,
	output var  logic                          o_read_ok,
	output var  logic                          o_ready_irq
);

	// ----------------------------------------
	// Derived sizes
	// ----------------------------------------
	localparam int LWW    = $clog2(PAGE_WORDS);
	localparam int NGRP   = (NUM_LOCKS + 31) / 32;
	localparam int PG_B   = PAGE_WORDS * 4;
	localparam int DLEN   = DESC_PLANE_IDX + NUM_PLANES + 1 + NUM_LOCKS;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		seq_state_t      st;          // Sequencer state
		logic            irq_en;      // Ready interrupt enable
		logic [3:0]      ws;          // Wait states
		logic            done;        // Command done flag
		logic            cerr;        // Command error flag
		logic            lerr;        // Lock error flag
		res_mode_t       rmode;       // What the result register shows
		logic [7:0]      ridx;        // Result word index
		logic [15:0]     page;        // Target page
		logic            erase_first; // Erase before programming
		logic            lock_after;  // Lock after programming
		logic [LWW-1:0]  widx;        // Word being programmed
		logic [3:0]      wcnt;        // Latch wait counter
		logic            pready;      // APB ready
		logic            pslverr;     // APB error
		logic [31:0]     prdata;      // APB read data
		logic            arr_req;     // Array request
		arr_op_t         arr_op;      // Array operation
		logic [31:0]     arr_wdata;   // Array write word
		logic            read_ok;     // Flash reads allowed
		logic            irq;         // Interrupt line
	} state_t;

	state_t         q;          // Registered state
	state_t         n;          // Next state
	logic           apb_acc;    // Access phase, not yet answered
	logic           is_lat;     // Address hits latch window
	logic           busy;       // Sequencer not idle
	logic [LWW-1:0] lat_ridx;   // Latch read index
	logic [31:0]    lat_rdata;  // Latch read word
	logic           lat_we;     // Latch write strobe
	logic           lk_set;     // Lock set strobe
	logic           lk_clr;     // Lock clear strobe
	logic [15:0]    lk_region;  // Region under test
	logic           lk_locked;  // That region is locked
	logic           lk_any;     // Some region is locked
	logic [31:0]    lk_word;    // Lock group word
	logic [31:0]    res_val;    // Current result word
	logic           cmd_wr;     // Command register write answered
	logic           key_ok;     // Keyword matches
	logic [7:0]     cmd_code;   // Command code field
	logic [15:0]    cmd_arg;    // Command argument field

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Region holding a page
	function automatic logic [15:0] region_of(input logic [15:0] pg);
		region_of = 16'(32'(pg) / REGION_PGS);
	endfunction

	// Descriptor word by index
	function automatic logic [31:0] desc_word(input logic [7:0] i);
		desc_word = 32'h0000_0000;
		if (i == 8'h00) begin
			desc_word = IFACE_WORD;
		end else if (i == 8'h01) begin
			desc_word = 32'(NUM_PAGES * PG_B);
		end else if (i == 8'h02) begin
			desc_word = 32'(PG_B);
		end else if (i == 8'h03) begin
			desc_word = 32'(NUM_PLANES);
		end else if (32'(i) < DESC_PLANE_IDX + NUM_PLANES) begin
			desc_word = 32'(NUM_PAGES * PG_B / NUM_PLANES);
		end else if (32'(i) == DESC_PLANE_IDX + NUM_PLANES) begin
			desc_word = 32'(NUM_LOCKS);
		end else if (32'(i) < DLEN) begin
			desc_word = 32'(REGION_PGS * PG_B);
		end
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	page_latch #(
		.WORDS (PAGE_WORDS)
	) u_latch (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_we    (lat_we),
		.i_widx  (i_paddr[2 +: LWW]),
		.i_wdata (i_pwdata),
		.i_ridx  (lat_ridx),
		.o_rdata (lat_rdata)
	);

	lock_regions #(
		.NUM_LOCKS (NUM_LOCKS)
	) u_locks (
		.i_clk        (i_clk),
		.i_rst_n      (i_rst_n),
		.i_set        (lk_set),
		.i_clr        (lk_clr),
		.i_region     (lk_region),
		.i_group      (q.ridx),
		.o_locked     (lk_locked),
		.o_any        (lk_any),
		.o_group_word (lk_word)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Whole upper window maps onto one page, so the latch repeats
	assign is_lat   = |i_paddr[11:10];
	assign busy     = q.st != ST_IDLE;
	assign apb_acc  = i_psel && i_penable && !q.pready;
	assign lat_ridx = busy ? q.widx : i_paddr[2 +: LWW];
	assign cmd_code = i_pwdata[CMD_CODE_LSB +: 8];
	assign cmd_arg  = i_pwdata[CMD_ARG_LSB +: 16];
	assign key_ok   = i_pwdata[CMD_KEY_LSB +: 8] == CMD_KEY;
	assign cmd_wr   = apb_acc && !is_lat && i_pwrite && i_paddr == CMD_OFS;
	assign lk_region = cmd_wr ? region_of(cmd_arg) : region_of(q.page);

	// Result word for the current index, zero once past the end
	always_comb begin
		res_val = 32'h0000_0000;
		case (q.rmode)
			RES_DESC: begin
				res_val = desc_word(q.ridx);
			end
			RES_LOCK: begin
				res_val = lk_word;
			end
			default: begin
				res_val = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		n      = q;
		lat_we = 1'b0;
		lk_set = 1'b0;
		lk_clr = 1'b0;

		// Sequencer walk
		case (q.st)
			ST_ERASE: begin
				if (!q.arr_req) begin
					n.arr_req = 1'b1;
				end else if (i_arr_ack) begin
					n.arr_req = 1'b0;
					n.st = (q.arr_op == OP_ERASE_ALL) ? ST_FINISH : ST_PROG;
				end
			end
			ST_PROG: begin
				// One word per handshake, straight from the latch
				if (!q.arr_req) begin
					n.arr_req   = 1'b1;
					n.arr_op    = OP_WRITE;
					n.arr_wdata = lat_rdata;
				end else if (i_arr_ack) begin
					n.arr_req = 1'b0;
					if (32'(q.widx) == PAGE_WORDS - 1) begin
						lk_set = q.lock_after;
						n.st   = ST_FINISH;
					end else begin
						n.widx = q.widx + 1'b1;
					end
				end
			end
			ST_FINISH: begin
				n.done = 1'b1;
				n.st   = ST_IDLE;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// APB slave: latch accesses wait, registers answer at once
		if (apb_acc) begin
			if (is_lat && q.wcnt != q.ws) begin
				n.wcnt = q.wcnt + 1'b1;
			end else begin
				n.wcnt    = 4'h0;
				n.pready  = 1'b1;
				n.pslverr = 1'b0;
				n.prdata  = 32'h0000_0000;
				if (is_lat) begin
					// Byte lanes are not offered; words only
					if (busy) begin
						n.pslverr = 1'b1;
					end else if (i_pwrite) begin
						lat_we = 1'b1;
					end else begin
						n.prdata = lat_rdata;
					end
				end else begin
					case (i_paddr)
						MODE_OFS: begin
							if (i_pwrite) begin
								n.irq_en = i_pwdata[MODE_IRQ_BIT];
								n.ws     = i_pwdata[MODE_WS_LSB +: 4];
							end else begin
								n.prdata[MODE_IRQ_BIT]    = q.irq_en;
								n.prdata[MODE_WS_LSB +: 4] = q.ws;
							end
						end
						CMD_OFS: begin
							if (!i_pwrite) begin
								n.prdata = 32'h0000_0000;
							end else if (!key_ok || busy) begin
								n.cerr = 1'b1;
							end else begin
								n.done  = 1'b0;
								n.rmode = RES_NONE;
								n.ridx  = 8'h00;
								n.page  = cmd_arg;
								n.widx  = '0;
								n.st    = ST_FINISH;
								case (cmd_code)
									WRITE_PAGE_CMD, WRITE_PAGE_LOCK_CMD,
									ERASE_WRITE_PAGE_CMD,
									ERASE_WRITE_PAGE_LOCK_CMD: begin
										if (lk_locked) begin
											n.lerr = 1'b1;
										end else begin
											// Plain write leaves erased cells alone
											n.erase_first = cmd_code[1:0] == 2'b11 ||
												cmd_code[2];
											n.lock_after = cmd_code == WRITE_PAGE_LOCK_CMD ||
												cmd_code == ERASE_WRITE_PAGE_LOCK_CMD;
											n.arr_op = OP_ERASE_PAGE;
											n.st = n.erase_first ? ST_ERASE : ST_PROG;
										end
									end
									ERASE_ALL_CMD: begin
										if (lk_any) begin
											n.lerr = 1'b1;
										end else begin
											n.arr_op = OP_ERASE_ALL;
											n.st     = ST_ERASE;
										end
									end
									SET_LOCK_CMD: begin
										lk_set = 1'b1;
									end
									CLEAR_LOCK_CMD: begin
										lk_clr = 1'b1;
									end
									GET_DESCRIPTOR_CMD: begin
										n.rmode = RES_DESC;
									end
									GET_LOCK_CMD: begin
										n.rmode = RES_LOCK;
									end
									default: begin
										n.cerr = 1'b1;
										n.done = q.done;
										n.st   = ST_IDLE;
									end
								endcase
							end
						end
						STAT_OFS: begin
							if (!i_pwrite) begin
								n.prdata[STAT_DONE_BIT] = q.done;
								n.prdata[STAT_CERR_BIT] = q.cerr;
								n.prdata[STAT_LERR_BIT] = q.lerr;
								n.cerr = 1'b0;
								n.lerr = 1'b0;
							end
						end
						RES_OFS: begin
							if (!i_pwrite) begin
								n.prdata = res_val;
								if (q.ridx != 8'hFF) begin
									n.ridx = q.ridx + 8'h01;
								end
							end
						end
						default: begin
							n.pslverr = 1'b1;
						end
					endcase
				end
			end
		end else begin
			n.pready = 1'b0;
		end

		// Reads stay open except while the array is busy
		n.read_ok = !(n.st == ST_ERASE || n.st == ST_PROG);
		n.irq     = n.done && n.irq_en;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q         <= '0;
			q.done    <= DONE_RESET;
			q.ws      <= WS_RESET;
			q.read_ok <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_prdata    = q.prdata;
	assign o_pready    = q.pready;
	assign o_pslverr   = q.pslverr;
	assign o_arr_req   = q.arr_req;
	assign o_arr_op    = q.arr_op;
	assign o_arr_page  = q.page;
	assign o_arr_widx  = q.widx;
	assign o_arr_wdata = q.arr_wdata;
	assign o_read_ok   = q.read_ok;
	assign o_ready_irq = q.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	logic cmd_go;   // Accepted command
	assign cmd_go = cmd_wr && key_ok && !busy && !(q.wcnt != q.ws && is_lat);

	chk_cmd_clear_done: assert property (
		cmd_go && cmd_code != 8'hFF && cmd_code != 8'h06 |=> !q.done || q.st == ST_IDLE)
		else $error("command did not clear done");
	chk_bad_key: assert property (cmd_wr && !key_ok |=> q.cerr)
		else $error("bad keyword not flagged");
	chk_locked_prog: assert property (
		cmd_go && cmd_code inside {[8'h01:8'h04]} && lk_locked
		|=> q.lerr && q.st == ST_FINISH ##1 q.done && !o_arr_req)
		else $error("locked page programmed");
	chk_ea_refused: assert property (
		cmd_go && cmd_code == ERASE_ALL_CMD && lk_any |=> q.lerr ##1 !o_arr_req)
		else $error("erase of locked area not refused");
	chk_erase_first: assert property (
		cmd_go && cmd_code == ERASE_WRITE_PAGE_CMD && !lk_locked
		|=> q.st == ST_ERASE ##1 o_arr_op == OP_ERASE_PAGE)
		else $error("no erase before write");
	chk_plain_write: assert property (
		cmd_go && cmd_code == WRITE_PAGE_CMD && !lk_locked |=> q.st == ST_PROG)
		else $error("plain write erased");
	chk_irq_done: assert property (
		q.st == ST_FINISH && q.irq_en && !apb_acc |=> o_ready_irq && q.done)
		else $error("done without interrupt");
	chk_status_clear: assert property (
		apb_acc && !is_lat && !i_pwrite && i_paddr == STAT_OFS |=> !q.cerr && !q.lerr)
		else $error("status read kept error");
	chk_latch_wait: assert property (
		apb_acc && is_lat && q.wcnt != q.ws |=> !o_pready)
		else $error("latch answered early");
	chk_reads_lock: assert property (q.st == ST_FINISH |-> o_read_ok)
		else $error("reads blocked on lock command");

	cov_program: cover property (q.st == ST_PROG ##1 q.st == ST_FINISH);
	cov_erase_all: cover property (q.arr_req && q.arr_op == OP_ERASE_ALL);
	cov_desc_read: cover property (q.rmode == RES_DESC && o_pready && q.ridx == 8'h05);

endmodule
`default_nettype wire

//--- flash_seq_pkg.sv
`default_nettype none
package flash_seq_pkg;

	// ----------------------------------------
	// Register offsets (APB byte addresses)
	// ----------------------------------------
	localparam logic [11:0] MODE_OFS = 12'h000;
	localparam logic [11:0] CMD_OFS  = 12'h004;
	localparam logic [11:0] STAT_OFS = 12'h008;
	localparam logic [11:0] RES_OFS  = 12'h00C;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MODE_IRQ_BIT  = 0;   // Ready interrupt enable
	localparam int MODE_WS_LSB   = 8;   // Wait state field, 4 bits
	localparam int STAT_DONE_BIT = 0;   // Command done flag
	localparam int STAT_CERR_BIT = 1;   // Command error flag
	localparam int STAT_LERR_BIT = 2;   // Lock error flag
	localparam int CMD_CODE_LSB  = 0;   // Command code field, 8 bits
	localparam int CMD_ARG_LSB   = 8;   // Argument field, 16 bits
	localparam int CMD_KEY_LSB   = 24;  // Protection keyword, 8 bits
	localparam int DESC_PLANE_IDX = 4;  // First per-plane size word

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic       DONE_RESET = 1'b1;
	localparam logic [3:0] WS_RESET   = 4'h0;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] GET_DESCRIPTOR_CMD        = 8'h00;
	localparam logic [7:0] WRITE_PAGE_CMD            = 8'h01;
	localparam logic [7:0] WRITE_PAGE_LOCK_CMD       = 8'h02;
	localparam logic [7:0] ERASE_WRITE_PAGE_CMD      = 8'h03;
	localparam logic [7:0] ERASE_WRITE_PAGE_LOCK_CMD = 8'h04;
	localparam logic [7:0] ERASE_ALL_CMD             = 8'h05;
	localparam logic [7:0] SET_LOCK_CMD              = 8'h08;
	localparam logic [7:0] CLEAR_LOCK_CMD            = 8'h09;
	localparam logic [7:0] GET_LOCK_CMD              = 8'h0A;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {
		OP_WRITE      = 2'b00,
		OP_ERASE_PAGE = 2'b01,
		OP_ERASE_ALL  = 2'b10
	} arr_op_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ERASE  = 3'b001,
		ST_PROG   = 3'b010,
		ST_FINISH = 3'b011
	} seq_state_t;

	typedef enum logic [1:0] {
		RES_NONE = 2'b00,
		RES_DESC = 2'b01,
		RES_LOCK = 2'b10
	} res_mode_t;

endpackage
`default_nettype wire

//--- page_latch.sv
`timescale 1ns/1ps
`default_nettype none
module page_latch #(
	parameter int WORDS = 16,
	parameter int IW    = $clog2(WORDS)
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	input  wire logic          i_we,
	input  wire logic [IW-1:0] i_widx,
	input  wire logic [31:0]   i_wdata,
	input  wire logic [IW-1:0] i_ridx,
	output var  logic [31:0]   o_rdata
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	typedef struct packed {
		logic [WORDS-1:0][31:0] mem;   // One page of words
	} latch_t;

	latch_t q;   // Registered contents
	latch_t d;   // Next contents

	// Only a write strobe alters a word, so a page sits
	// untouched until programming consumes it
	always_comb begin
		d = q;
		if (i_we) begin
			d.mem[i_widx] = i_wdata;
		end
	end

	// Register the copy
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Combinational read port
	assign o_rdata = q.mem[i_ridx];

endmodule
`default_nettype wire

//--- lock_regions.sv
`timescale 1ns/1ps
`default_nettype none
module lock_regions #(
	parameter int NUM_LOCKS = 16,
	parameter int NGRP      = (NUM_LOCKS + 31) / 32
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_set,
	input  wire logic        i_clr,
	input  wire logic [15:0] i_region,
	input  wire logic [7:0]  i_group,
	output var  logic        o_locked,
	output var  logic        o_any,
	output var  logic [31:0] o_group_word
);

	// ----------------------------------------
	// Lock bits
	// ----------------------------------------
	// Volatile here; a real part keeps them in the array
	typedef struct packed {
		logic [NUM_LOCKS-1:0] bits;   // One bit per region
	} locks_t;

	locks_t                 q;       // Registered bits
	locks_t                 d;       // Next bits
	logic                   in_rng;  // Region is implemented
	logic [NGRP*32-1:0]     padded;  // Bits padded to words

	assign in_rng = 32'(i_region) < NUM_LOCKS;

	// Out-of-range regions leave every bit alone
	always_comb begin
		d = q;
		if (in_rng && i_set) begin
			d.bits[i_region[$clog2(NUM_LOCKS)-1:0]] = 1'b1;
		end else if (in_rng && i_clr) begin
			d.bits[i_region[$clog2(NUM_LOCKS)-1:0]] = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Locked status and group words, bit n is region n of group
	assign o_locked = in_rng && q.bits[i_region[$clog2(NUM_LOCKS)-1:0]];
	assign o_any    = |q.bits;
	assign padded   = (NGRP*32)'(q.bits);
	assign o_group_word = (32'(i_group) < NGRP) ?
		padded[32'(i_group)*32 +: 32] : 32'h0000_0000;

endmodule
`default_nettype wire

//--- flash_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_sequencer_tb_top
	import flash_seq_pkg::*;
();
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, ack = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wd = 32'h0, prd, awd, rd, st;
	logic        rdy, serr, req, rok, irq, er;
	logic [1:0]  op;
	logic [15:0] pg;
	logic [3:0]  widx;
	logic [31:0] lat[16];        // Expected latch image
	logic [31:0] qop[$], qwd[$]; // Array handshakes seen: {op,page,widx}, data
	integer      seed = 32'h78F2;
	int          num_errors = 0, total_checks = 0, lastn = 0, i;

	always #5 i_clk = ~i_clk;

	flash_sequencer #(.IFACE_WORD(32'h0000_5A5A)) u_dut ( // Arbitrary identity value
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(prd),
		.o_pready(rdy), .o_pslverr(serr), .o_arr_req(req), .o_arr_op(op),
		.o_arr_page(pg), .o_arr_widx(widx), .o_arr_wdata(awd), .i_arr_ack(ack),
		.o_read_ok(rok), .o_ready_irq(irq));

	// ----------------------------------------
	// Array stand-in: random ack delay, log
	// ----------------------------------------
	always @(posedge i_clk) begin
		ack <= req && !ack && ($random(seed) % 2 != 0);
		if (req && ack) begin
			qop.push_back({10'h0, op, pg, widx});
			qwd.push_back(awd);
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Full APB cycle; waits on pready, bounded by the watchdog
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1; pwr <= w; addr <= a; wd <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		lastn = 0;
		do begin
			@(posedge i_clk);
			lastn++;
		end while (rdy !== 1'b1);
		rd = prd;
		er = serr;
		psel <= 1'b0; pen <= 1'b0;
	endtask

	// Poll status until done; error bits are sticky here since reads clear them
	task fin;
		st = 32'h0;
		do begin
			apb(1'b0, STAT_OFS, 32'h0);
			st |= rd;
		end while (rd[0] !== 1'b1);
	endtask

	task cmd(input logic [7:0] c, input logic [15:0] a, input logic [7:0] k = 8'hC3);
		qop.delete();
		apb(1'b1, CMD_OFS, {k, a, c});
		if (c >= SET_LOCK_CMD) chk({31'h0, rok}, 32'h1);
		fin();
	endtask

	// Fill latch at scattered page slots, program, expect n transfers
	task prog(input logic [7:0] c, input logic [15:0] p, input int n);
		int k, e;
		e = (n == 17);
		for (k = 0; k < 16; k++) begin
			lat[k] = $random(seed);
			apb(1'b1, 12'h400 | (12'($random(seed)) & 12'h7C0) | 12'(k * 4), lat[k]);
		end
		qop.delete(); qwd.delete();
		apb(1'b1, CMD_OFS, {8'hC3, p, c});
		repeat (2) @(posedge i_clk);
		if (n != 0) chk({31'h0, irq}, 32'h0);
		if (n != 0) chk({31'h0, rok}, 32'h0);
		if (n != 0) begin
			// While busy, latch and command writes must both bounce
			apb(1'b1, 12'h400, 32'h0);
			chk({31'h0, er}, 32'h1);
			apb(1'b1, CMD_OFS, {8'hC3, p, c});
		end
		fin();
		chk({31'h0, st[1]}, 32'(n != 0));
		chk(32'(qop.size()), 32'(n));
		chk({31'h0, st[2]}, 32'(n == 0));
		chk({31'h0, irq}, 32'h1);
		if (e) chk({14'h0, qop[0][21:4]}, {14'h0, 2'b01, p});
		for (k = 0; k < n - e; k++) begin
			chk(qop[k + e], {10'h0, 2'b00, p, 4'(k)});
			chk(qwd[k + e], lat[k]);
		end
		$display("test program %h page %0d done", c, p);
	endtask

	function automatic logic [31:0] dsc(input int j);
		case (j)
			0:       return 32'h0000_5A5A;
			1, 4:    return 32'h0000_4000;
			2:       return 32'h0000_0040;
			3:       return 32'h0000_0001;
			5:       return 32'h0000_0010;
			// One region-size word per lock bit, zeros past the end
			default: return (j >= 6 && j < 22) ? 32'h0000_0400 : 32'h0;
		endcase
	endfunction

	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, MODE_OFS, 32'h0000_0201);
		apb(1'b0, MODE_OFS, 32'h0);
		chk(rd, 32'h0000_0201);
		apb(1'b1, 12'hC04, 32'h0);
		chk(32'(lastn), 32'h4);
		cmd(GET_DESCRIPTOR_CMD, 16'($random(seed)));
		for (i = 0; i < 24; i++) begin
			apb(1'b0, RES_OFS, 32'h0);
			chk(rd, dsc(i));
		end
		$display("test descriptor done");
		prog(WRITE_PAGE_CMD, 16'd3, 16);
		prog(ERASE_WRITE_PAGE_CMD, 16'd5, 17);
		prog(ERASE_WRITE_PAGE_LOCK_CMD, 16'd20, 17);
		prog(WRITE_PAGE_LOCK_CMD, 16'd40, 16);
		prog(WRITE_PAGE_CMD, 16'd17, 0);
		cmd(GET_LOCK_CMD, 16'($random(seed)));
		apb(1'b0, RES_OFS, 32'h0);
		chk(rd, 32'h0000_0006);
		apb(1'b0, RES_OFS, 32'h0);
		chk(rd, 32'h0);
		cmd(ERASE_ALL_CMD, 16'h0);
		chk({st[2], 31'(qop.size())}, 32'h8000_0000);
		cmd(CLEAR_LOCK_CMD, 16'd16);
		cmd(CLEAR_LOCK_CMD, 16'd33);
		cmd(SET_LOCK_CMD, 16'd255);
		cmd(SET_LOCK_CMD, 16'd256);
		apb(1'b0, RES_OFS, 32'h0);
		chk(rd, 32'h0);
		cmd(GET_LOCK_CMD, 16'($random(seed)));
		apb(1'b0, RES_OFS, 32'h0);
		chk(rd, 32'h0000_8000);
		cmd(CLEAR_LOCK_CMD, 16'd250);
		cmd(ERASE_ALL_CMD, 16'h0);
		chk({30'h0, qop[0][21:20]}, 32'h2);
		$display("test locks done");
		cmd(SET_LOCK_CMD, 16'd0, 8'h3C);
		chk({31'h0, st[1]}, 32'h1);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rd, 32'h1);
		cmd(8'h07, 16'h0);
		chk({31'h0, st[1]}, 32'h1);
		apb(1'b1, MODE_OFS, 32'h0);
		repeat (2) @(posedge i_clk);
		chk({31'h0, irq}, 32'h0);
		$display("test errors done");
		give_verdict();
	end

	// Watchdog: whole run needs well under this span
	initial begin
		#500000;
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
